// ### tb.sv
// Self-checking testbench of the timer channel, driving it over APB
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk_sys, srst, psel, penable, pwrite, noise, fire1;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r, c;
	logic pready, pslverr, e, cap0, cap1, main_o, aux_o, irq_p, irq_d, irq_o;
	int err_total, n_checks, cycles;
	// Device under test
	tpfr_timer tpfr_timer_i (.clk_sys(clk_sys), .srst(srst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .capture_in0(cap0), .capture_in1(cap1), .main_pulse_out(main_o),
		.aux_pulse_out(aux_o), .period_match_irq(irq_p), .duty_match_irq(irq_d),
		.overflow_irq(irq_o));
	// Capture pin sources
	tpfr_pins tpfr_pins_i (.clk_sys(clk_sys), .srst(srst), .noise(noise), .fire1(fire1),
		.capture_in0(cap0), .capture_in1(cap1));
	// Free-running 100 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Verdict and end of run
	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Hang guard
	initial
	begin
		cycles = 0;
		forever
		begin
			@(posedge clk_sys);
			cycles++;
			if (cycles == 90000)
			begin
				err_total++;
				$display("ERROR %0t: run too long", $time);
				stop_test;
			end
		end
	end
	// Value comparison
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Range comparison for values that depend on bus latency
	task check_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		n_checks++;
		if ((^got === 1'bx) || got < lo || got > hi)
		begin
			err_total++;
			$display("ERROR %0t: %h outside %h..%h", $time, got, lo, hi);
		end
	endtask
	// One APB transfer; request held until pready is sampled high
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk_sys);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
			check(1'b0, 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Register write and read
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask
	// Wait for an interrupt pulse: 0 period/ch0, 1 duty/ch1, 2 overflow
	task wait_irq(input int which, input int lim);
		int i;
		logic s;
		for (i = 0; i < lim; i++)
		begin
			@(posedge clk_sys);
			#1;
			s = (which == 0) ? irq_p : (which == 1) ? irq_d : irq_o;
			if (s === 1'b1)
				break;
		end
		if (i == lim)
			check(1'b0, 1'b1);
	endtask
	// Measure n cycles of PWM from a period clear, after the buffers surely loaded
	task run(input int n, input int e_hi, input int e_pi, input int e_di, input int e_ax);
		int i, hi, pi, di, ax, bad;
		logic last;
		hi = 0;
		pi = 0;
		di = 0;
		ax = 0;
		bad = 0;
		wait_irq(0, 300);
		wait_irq(0, 300);
		last = aux_o;
		for (i = 0; i < n; i++)
		begin
			if (i > 0)
			begin
				@(posedge clk_sys);
				#1;
			end
			hi += (main_o === 1'b1);
			pi += (irq_p === 1'b1);
			di += (irq_d === 1'b1);
			ax += (aux_o !== last);
			bad += (irq_d === 1'b1 && main_o !== 1'b0);
			last = aux_o;
		end
		check(hi, e_hi);
		check(pi, e_pi);
		check(di, e_di);
		check(ax, e_ax);
		check(bad, 0);
	endtask
	// Main sequence
	initial
	begin
		err_total = 0;
		n_checks = 0;
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		noise = 1'b0;
		fire1 = 1'b0;
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		// Reset values and an unmapped address
		rd(tpfr_pkg::ADDR_CTRL);
		check(r, 32'h0);
		rd(tpfr_pkg::ADDR_DUTY);
		check(r, 32'h0);
		rd(tpfr_pkg::ADDR_COUNT);
		check(r, 32'h0000ffff);
		rd(8'h1c);
		check(r, 32'h0);
		check(e, 1'b1);
		$display("test reset done");
		// PWM with noisy capture pins and option bits set
		wr(tpfr_pkg::ADDR_OPT, 32'h30);
		noise <= 1'b1;
		wr(tpfr_pkg::ADDR_PERIOD, 32'h4);
		wr(tpfr_pkg::ADDR_DUTY, 32'h2);
		wr(tpfr_pkg::ADDR_CTRL, 32'h84);
		run(10, 4, 2, 2, 1);
		wr(tpfr_pkg::ADDR_PERIOD, 32'h7);
		run(10, 4, 2, 2, 1);
		wr(tpfr_pkg::ADDR_DUTY, 32'h8);
		run(16, 16, 2, 0, 1);
		wr(tpfr_pkg::ADDR_DUTY, 32'h0);
		run(16, 0, 2, 2, 1);
		$display("test pwm done");
		// Free run: ch0 compare, ch1 capture on rising edges
		noise <= 1'b0;
		wr(tpfr_pkg::ADDR_CTRL, 32'h0);
		rd(tpfr_pkg::ADDR_COUNT);
		check(r, 32'h0000ffff);
		wr(tpfr_pkg::ADDR_OPT, 32'h20);
		wr(tpfr_pkg::ADDR_IOC1, 32'h4);
		wr(tpfr_pkg::ADDR_PERIOD, 32'h40);
		wr(tpfr_pkg::ADDR_CTRL, 32'h85);
		repeat (2) @(posedge clk_sys);
		#1;
		check({main_o, aux_o}, 2'b11);
		wait_irq(0, 100);
		check(aux_o, 1'b0);
		rd(tpfr_pkg::ADDR_COUNT);
		check_rng(r, 32'h43, 32'h48);
		rd(tpfr_pkg::ADDR_COUNT);
		wr(tpfr_pkg::ADDR_PERIOD, r + 32'h10);
		wait_irq(0, 40);
		check(aux_o, 1'b1);
		rd(tpfr_pkg::ADDR_COUNT);
		c = r;
		fire1 <= 1'b1;
		wait_irq(1, 20);
		fire1 <= 1'b0;
		rd(tpfr_pkg::ADDR_DUTY);
		check_rng(r, c, c + 32'h14);
		$display("test free run done");
		// Wrap, overflow flag and its clearing
		wait_irq(2, 70000);
		rd(tpfr_pkg::ADDR_OPT);
		check(r, 32'h21);
		rd(tpfr_pkg::ADDR_COUNT);
		check_rng(r, 32'h0, 32'h10);
		wr(tpfr_pkg::ADDR_OPT, 32'h21);
		rd(tpfr_pkg::ADDR_OPT);
		check(r, 32'h21);
		wr(tpfr_pkg::ADDR_OPT, 32'h20);
		rd(tpfr_pkg::ADDR_OPT);
		check(r, 32'h20);
		$display("test overflow done");
		stop_test;
	end
endmodule
`default_nettype wire

// ### tpfr_pins.sv
// Model of the pins around the timer: sources for the two capture inputs
`timescale 1ns/1ns
`default_nettype none
module tpfr_pins (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic noise,
	input wire logic fire1,
	output logic capture_in0,
	output logic capture_in1
);
	// Pins change just after the clock edge, like the synchronous source they stand for
	always_ff @(posedge clk_sys)
	begin
		// Quiet pins in reset
		if (srst)
		begin
			capture_in0 <= 1'b0;
			capture_in1 <= 1'b0;
		end
		// Busy edges on both pins, which PWM mode has to ignore
		else if (noise)
		begin
			capture_in0 <= ~capture_in0;
			capture_in1 <= ~capture_in1;
		end
		// Otherwise pin 1 gives one edge on request
		else
		begin
			capture_in0 <= 1'b0;
			capture_in1 <= fire1;
		end
	end
endmodule
`default_nettype wire

// ### tpfr_pkg.sv
// Package with register map, field layouts and mode codes of the timer channel
package tpfr_pkg;
	// Byte offsets of the registers on the APB
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_OPT = 8'h04;
	localparam logic [7:0] ADDR_IOC1 = 8'h08;
	localparam logic [7:0] ADDR_IOC2 = 8'h0c;
	localparam logic [7:0] ADDR_PERIOD = 8'h10;
	localparam logic [7:0] ADDR_DUTY = 8'h14;
	localparam logic [7:0] ADDR_COUNT = 8'h18;
	// Mode codes of the mode field
	localparam logic [2:0] MODE_PWM = 3'h4;
	localparam logic [2:0] MODE_FREE = 3'h5;
	// Counter limits
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] OPT_RST = 8'h00;
	localparam logic [7:0] IOC_RST = 8'h00;
	localparam logic [15:0] CCR_RST = 16'h0000;
	// Edge select codes, two bits per capture channel
	localparam int EDGE_RISE_BIT = 0;
	localparam int EDGE_FALL_BIT = 1;
	// Control register layout
	typedef struct packed {
		logic count_enable_bit;
		logic [3:0] pad;
		logic [2:0] mode_select;
	} tpfr_ctrl_type;
	// Option register layout
	typedef struct packed {
		logic [1:0] pad_hi;
		logic capcomp_select1;
		logic capcomp_select0;
		logic [2:0] pad_lo;
		logic overflow_flag;
	} tpfr_opt_type;
	// Run states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_PWM = 3'h2,
		ST_FREE = 3'h4
	} tpfr_state_type;
endpackage

// ### tpfr_timer.sv
// Timer channel with PWM and free-running modes behind an APB slave
// How it works
// - PWM mode: start from FFFF, drive main output
// - Aux output toggles once per PWM period
// - Width is duty, cycle is period plus one
// - Compare buffers load only at period clear
// - Only a duty write arms the buffer load
// - Period interrupt when counter clears to zero
// - Duty interrupt on the match, with main edge
// - Duty zero gives zero percent, interrupt kept
// - Duty period plus one gives full output
// - PWM ignores option and second io control
// - Free-run start inverts both outputs
// - Option bits pick compare or capture per channel
// - Compare value D hits when counter reaches D+1
// - After FFFF: overflow interrupt, flag, wrap
// - Overflow flag cleared by writing zero
// - Free-run compare writes apply at once
// - Capture edge stores count and interrupts
// - Count readback returns live counter
// - Overflow set beats simultaneous clear
`timescale 1ns/1ns
`default_nettype none
module tpfr_timer #(
	parameter int unsigned CLK_DIV = 1
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_in0,
	input wire logic capture_in1,
	output logic main_pulse_out,
	output logic aux_pulse_out,
	output logic period_match_irq,
	output logic duty_match_irq,
	output logic overflow_irq
);
	// Software visible registers
	tpfr_pkg::tpfr_ctrl_type control_reg0; // Enable and mode
	tpfr_pkg::tpfr_opt_type option_reg0; // Select bits and flag
	logic [7:0] io_control1; // Capture edge selects
	logic [7:0] io_control2; // Stored only
	logic [15:0] chan_reg [2]; // Channel registers
	logic [15:0] period_compare; // Channel 0 register
	logic [15:0] duty_compare; // Channel 1 register
	// Core state
	tpfr_pkg::tpfr_state_type state; // Run state
	tpfr_pkg::tpfr_state_type next_state; // Next run state
	logic [15:0] cnt; // The 16-bit counter
	logic [15:0] period_buf; // Period compare buffer
	logic [15:0] duty_buf; // Duty compare buffer
	logic armed; // Buffer load requested
	logic fresh; // First count after start
	logic [15:0] div_cnt; // Count clock divider
	logic [1:0] cap_prev; // Last capture pin levels

	// Channel register aliases
	assign period_compare = chan_reg[0];
	assign duty_compare = chan_reg[1];

	// APB decode
	wire logic access = psel & penable;
	wire logic commit = access & pready;
	wire logic sel_ctrl = paddr == tpfr_pkg::ADDR_CTRL;
	wire logic sel_opt = paddr == tpfr_pkg::ADDR_OPT;
	wire logic sel_ioc1 = paddr == tpfr_pkg::ADDR_IOC1;
	wire logic sel_ioc2 = paddr == tpfr_pkg::ADDR_IOC2;
	wire logic sel_per = paddr == tpfr_pkg::ADDR_PERIOD;
	wire logic sel_duty = paddr == tpfr_pkg::ADDR_DUTY;
	wire logic sel_cnt = paddr == tpfr_pkg::ADDR_COUNT;
	wire logic hit = sel_ctrl | sel_opt | sel_ioc1 | sel_ioc2 | sel_per | sel_duty | sel_cnt;
	wire logic wr = commit & pwrite;
	wire logic wr_ctrl = wr & sel_ctrl;
	wire logic wr_opt = wr & sel_opt;
	wire logic [1:0] wr_chan = {wr & sel_duty, wr & sel_per};

	// Read data selection; counter is sampled live
	wire logic [31:0] rd_data =
		sel_ctrl ? {24'h000000, control_reg0} :
		sel_opt ? {24'h000000, option_reg0} :
		sel_ioc1 ? {24'h000000, io_control1} :
		sel_ioc2 ? {24'h000000, io_control2} :
		sel_per ? {16'h0000, period_compare} :
		sel_duty ? {16'h0000, duty_compare} :
		sel_cnt ? {16'h0000, cnt} :
		32'h00000000;

	// Count clock enable from the divider
	wire logic tick = div_cnt == 16'(CLK_DIV - 1);
	wire logic ce = control_reg0.count_enable_bit;
	wire logic [2:0] mode = control_reg0.mode_select;
	wire logic pwm_tick = (state == tpfr_pkg::ST_PWM) & tick;
	wire logic free_tick = (state == tpfr_pkg::ST_FREE) & tick;
	wire logic start = (state == tpfr_pkg::ST_IDLE) & (next_state != tpfr_pkg::ST_IDLE);
	wire logic free_start = start & (next_state == tpfr_pkg::ST_FREE);
	wire logic [15:0] cnt_inc = cnt + tpfr_pkg::CNT_ONE;

	// PWM period end: first count after start or period match
	wire logic pwm_wrap = pwm_tick & (fresh | (cnt == period_buf));
	// Buffers load at the first clear after start, later only if armed by a duty write
	wire logic load_buf = pwm_wrap & (fresh | armed);
	wire logic [15:0] duty_eff = load_buf ? duty_compare : duty_buf;
	// Duty match on the cycle before the counter reaches the duty buffer
	wire logic pwm_duty_hit = pwm_tick &
		(pwm_wrap ? (duty_eff == tpfr_pkg::CNT_ZERO) : (cnt_inc == duty_buf));
	wire logic pwm_period_evt = pwm_wrap & ~fresh;
	// Overflow when counting on from FFFF
	wire logic ovf_evt = free_tick & ~fresh & (cnt == tpfr_pkg::CNT_MAX);
	wire logic ovf_clr = wr_opt & ~pwdata[0];

	// Per channel capture and compare events
	logic [1:0] ccs; // Capture select per channel
	logic [1:0] cap_pin; // Capture pins
	logic [1:0] cap_edge; // Valid capture edge seen
	logic [1:0] cmp_hit; // Compare match seen
	logic [1:0] ch_evt; // Channel event
	assign ccs = {option_reg0.capcomp_select1, option_reg0.capcomp_select0};
	assign cap_pin = {capture_in1, capture_in0};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_chan
			// Edge select pair of this channel
			wire logic [1:0] esel = io_control1[2*gi+1:2*gi];
			wire logic rise = cap_pin[gi] & ~cap_prev[gi];
			wire logic fall = ~cap_pin[gi] & cap_prev[gi];
			// Capture only in free-run; PWM ignores the option bits
			assign cap_edge[gi] = (state == tpfr_pkg::ST_FREE) & ccs[gi] &
				((rise & esel[tpfr_pkg::EDGE_RISE_BIT]) |
				(fall & esel[tpfr_pkg::EDGE_FALL_BIT]));
			// Register read directly, so writes apply at once
			assign cmp_hit[gi] = free_tick & ~fresh & ~ccs[gi] & (cnt == chan_reg[gi]);
			assign ch_evt[gi] = cap_edge[gi] | cmp_hit[gi];
			// Channel register: capture beats a software write
			always_ff @(posedge clk_sys)
			begin
				if (srst)
					chan_reg[gi] <= tpfr_pkg::CCR_RST;
				else if (cap_edge[gi])
					chan_reg[gi] <= cnt;
				else if (wr_chan[gi])
					chan_reg[gi] <= pwdata[15:0];
			end
			// Previous pin level for edge detection
			always_ff @(posedge clk_sys)
			begin
				if (srst)
					cap_prev[gi] <= 1'b0;
				else
					cap_prev[gi] <= cap_pin[gi];
			end
		end
	endgenerate

	// Next run state from enable and mode
	always_comb
	begin
		next_state = state;
		case (state)
			tpfr_pkg::ST_IDLE:
				if (ce && mode == tpfr_pkg::MODE_PWM)
					next_state = tpfr_pkg::ST_PWM;
				else if (ce && mode == tpfr_pkg::MODE_FREE)
					next_state = tpfr_pkg::ST_FREE;
			tpfr_pkg::ST_PWM:
				if (!ce || mode != tpfr_pkg::MODE_PWM)
					next_state = tpfr_pkg::ST_IDLE;
			tpfr_pkg::ST_FREE:
				if (!ce || mode != tpfr_pkg::MODE_FREE)
					next_state = tpfr_pkg::ST_IDLE;
			default:
				next_state = tpfr_pkg::ST_IDLE;
		endcase
	end

	// Run state register
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			state <= tpfr_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// Count clock divider, reset while idle
	always_ff @(posedge clk_sys)
	begin
		if (srst || state == tpfr_pkg::ST_IDLE || tick)
			div_cnt <= 16'h0000;
		else
			div_cnt <= div_cnt + 16'h0001;
	end

	// Counter: holds FFFF when idle, clears at PWM period end
	always_ff @(posedge clk_sys)
	begin
		if (srst || state == tpfr_pkg::ST_IDLE)
			cnt <= tpfr_pkg::CNT_MAX;
		else if (pwm_wrap)
			cnt <= tpfr_pkg::CNT_ZERO;
		else if (tick)
			cnt <= cnt_inc;
	end

	// First count marker after each start
	always_ff @(posedge clk_sys)
	begin
		if (srst || state == tpfr_pkg::ST_IDLE)
			fresh <= 1'b1;
		else if (tick)
			fresh <= 1'b0;
	end

	// Compare buffers, loaded only at period clear
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			period_buf <= tpfr_pkg::CCR_RST;
			duty_buf <= tpfr_pkg::CCR_RST;
		end
		else if (load_buf)
		begin
			period_buf <= period_compare;
			duty_buf <= duty_compare;
		end
	end

	// Load request: set by a duty write in PWM, write beats the load
	always_ff @(posedge clk_sys)
	begin
		if (srst || state != tpfr_pkg::ST_PWM)
			armed <= 1'b0;
		else if (wr_chan[1])
			armed <= 1'b1;
		else if (load_buf)
			armed <= 1'b0;
	end

	// Main output: PWM level or channel 1 toggle
	always_ff @(posedge clk_sys)
	begin
		if (srst || state == tpfr_pkg::ST_IDLE && !free_start)
			main_pulse_out <= 1'b0;
		else if (free_start)
			main_pulse_out <= ~main_pulse_out;
		else if (pwm_duty_hit)
			main_pulse_out <= 1'b0;
		else if (pwm_wrap)
			main_pulse_out <= 1'b1;
		else if (cmp_hit[1])
			main_pulse_out <= ~main_pulse_out;
	end

	// Aux output: toggles each PWM period or on channel 0 match
	always_ff @(posedge clk_sys)
	begin
		if (srst || state == tpfr_pkg::ST_IDLE && !free_start)
			aux_pulse_out <= 1'b0;
		else if (free_start || pwm_period_evt || cmp_hit[0])
			aux_pulse_out <= ~aux_pulse_out;
	end

	// Interrupt pulses, one clock each
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			period_match_irq <= 1'b0;
			duty_match_irq <= 1'b0;
			overflow_irq <= 1'b0;
		end
		else
		begin
			period_match_irq <= pwm_period_evt | ch_evt[0];
			duty_match_irq <= pwm_duty_hit | ch_evt[1];
			overflow_irq <= ovf_evt;
		end
	end

	// Control and io registers
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			control_reg0 <= tpfr_pkg::CTRL_RST;
			io_control1 <= tpfr_pkg::IOC_RST;
			io_control2 <= tpfr_pkg::IOC_RST;
		end
		else
		begin
			if (wr_ctrl)
			begin
				control_reg0.count_enable_bit <= pwdata[7];
				control_reg0.mode_select <= pwdata[2:0];
			end
			if (wr & sel_ioc1)
				io_control1 <= pwdata[7:0];
			if (wr & sel_ioc2)
				io_control2 <= pwdata[7:0];
		end
	end

	// Option register; overflow set wins over a clear
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			option_reg0 <= tpfr_pkg::OPT_RST;
		else
		begin
			if (wr_opt)
			begin
				option_reg0.capcomp_select1 <= pwdata[5];
				option_reg0.capcomp_select0 <= pwdata[4];
			end
			if (ovf_evt)
				option_reg0.overflow_flag <= 1'b1;
			else if (ovf_clr)
				option_reg0.overflow_flag <= 1'b0;
		end
	end

	// APB answer: one wait state, data and error registered
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= access & ~pready;
			pslverr <= access & ~pready & ~hit;
			if (access && !pready && !pwrite)
				prdata <= rd_data;
		end
	end

	// Overflow sets the flag despite any clear
	ovf_flag_set_a: assert property (@(posedge clk_sys) disable iff (srst)
		ovf_evt |=> option_reg0.overflow_flag)
		else $error("overflow flag not set");
	// Overflow pulse comes with the wrap to zero
	ovf_irq_wrap_a: assert property (@(posedge clk_sys) disable iff (srst)
		ovf_evt |=> overflow_irq && cnt == tpfr_pkg::CNT_ZERO && !$past(overflow_irq))
		else $error("overflow pulse or wrap wrong");
	// Period pulse with counter clear
	period_irq_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
		pwm_period_evt |=> period_match_irq && cnt == tpfr_pkg::CNT_ZERO)
		else $error("period pulse not with clear");
	// Duty pulse coincides with main going low
	duty_irq_edge_a: assert property (@(posedge clk_sys) disable iff (srst)
		pwm_duty_hit |=> duty_match_irq && !main_pulse_out)
		else $error("duty pulse not with main edge");
	// Aux flips at every period end
	aux_period_toggle_a: assert property (@(posedge clk_sys) disable iff (srst)
		pwm_period_evt |=> aux_pulse_out != $past(aux_pulse_out))
		else $error("aux did not toggle");
	// Buffer unchanged away from a load
	buf_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
		!load_buf |=> period_buf == $past(period_buf) && duty_buf == $past(duty_buf))
		else $error("buffer changed outside load");
	// Period write alone never reaches the period buffer at a clear
	period_only_a: assert property (@(posedge clk_sys) disable iff (srst)
		(pwm_wrap && !fresh && !armed) |=> period_buf == $past(period_buf))
		else $error("load without duty write");
	// Free start inverts both outputs
	free_start_inv_a: assert property (@(posedge clk_sys) disable iff (srst)
		free_start |=> main_pulse_out != $past(main_pulse_out)
			&& aux_pulse_out != $past(aux_pulse_out))
		else $error("outputs not inverted at start");
	// Compare hit lands on D plus one
	cmp_d_plus_a: assert property (@(posedge clk_sys) disable iff (srst)
		cmp_hit[1] |=> duty_match_irq && cnt == $past(duty_compare) + tpfr_pkg::CNT_ONE
			&& main_pulse_out != $past(main_pulse_out))
		else $error("compare match wrong");
	// Capture stores the count and pulses
	capture_store_a: assert property (@(posedge clk_sys) disable iff (srst)
		cap_edge[1] |=> duty_compare == $past(cnt) && duty_match_irq)
		else $error("capture not stored");
	// Idle counter sits at FFFF
	idle_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
		state == tpfr_pkg::ST_IDLE |=> cnt == tpfr_pkg::CNT_MAX)
		else $error("idle counter not at max");
	// Count readback shows the live counter
	count_read_a: assert property (@(posedge clk_sys) disable iff (srst)
		(access && !pready && !pwrite && sel_cnt) |=> pready && prdata[15:0] == $past(cnt))
		else $error("readback mismatch");
endmodule
`default_nettype wire
